/* File: include/tlih_pkg.sv */
// Purpose: shared constants, types and helpers of the interrupt handler
// Assumes: 8-bit register port, 19 sources, one system clock
// Notes:   sources 0 and 2 are also fed from the two external pins
package tlih_pkg;

  // ==========================================================
  // sources and vectors
  localparam int              NUM_SRC     = 19;
  localparam int              SRC_W       = 5;
  localparam int              EXT0_SRC    = 0;
  localparam int              EXT1_SRC    = 2;
  localparam logic [15:0]     RESET_VEC   = 16'h0000;
  localparam logic [15:0]     VEC_BASE    = 16'h0003;
  localparam logic [18:0]     HW_CLR_MASK = 19'h0000F;

  // ==========================================================
  // register offsets
  localparam logic [7:0]      OFS_EN0     = 8'h00;
  localparam logic [7:0]      OFS_EN1     = 8'h01;
  localparam logic [7:0]      OFS_EN2     = 8'h02;
  localparam logic [7:0]      OFS_PRI0    = 8'h03;
  localparam logic [7:0]      OFS_PRI1    = 8'h04;
  localparam logic [7:0]      OFS_PRI2    = 8'h05;
  localparam logic [7:0]      OFS_PND0    = 8'h06;
  localparam logic [7:0]      OFS_PND1    = 8'h07;
  localparam logic [7:0]      OFS_PND2    = 8'h08;
  localparam logic [7:0]      OFS_STAT    = 8'h09;
  localparam int              GLB_EN_BIT  = 7;

  // ==========================================================
  // reset values
  localparam logic [18:0]     EN_RST      = 19'h00000;
  localparam logic [18:0]     PRI_RST     = 19'h00000;
  localparam logic [18:0]     PND_RST     = 19'h00000;
  localparam logic            GLB_EN_RST  = 1'b0;

  // ==========================================================
  // timing: clock period in ns, the rest in system clock cycles
  localparam int              CLK_PERIOD_NS = 8;
  localparam int              DETECT_CYC    = 1;
  localparam int              CALL_CYC      = 5;
  localparam int              RESP_MIN_CYC  = 7;
  localparam int              RESP_MAX_CYC  = 19;

  // ==========================================================
  // types
  typedef enum logic {LVL_LOW = 1'b0, LVL_HIGH = 1'b1} tlih_level_t;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LOW  = 2'b01,
    SVC_NEST = 2'b11,
    SVC_HIGH = 2'b10
  } tlih_svc_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tlih_bus_t;

  typedef struct packed {
    logic              valid;
    tlih_level_t       level;
    logic [SRC_W-1:0]  src;
    logic [15:0]       vector;
  } tlih_req_t;

  // ==========================================================
  // helpers
  function automatic logic [23:0] to_bytes(input logic [18:0] v);
    return {4'h0, v[18:15], v[14:7], 1'b0, v[6:0]};
  endfunction

  function automatic logic [18:0] from_bytes(input logic [23:0] b);
    return {b[19:16], b[15:8], b[6:0]};
  endfunction

  function automatic logic [SRC_W-1:0] first_src(input logic [18:0] v);
    logic [SRC_W-1:0] id;
    id = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        id = SRC_W'(i);
      end
    end
    return id;
  endfunction

endpackage

/* File: rtl/tlih_core.sv */
// Purpose: two-level interrupt handler beside an 8-bit core sequencer
// Assumes: sources pulse on clock_in; pins are asynchronous, active low
// Notes:   core takes a request with take_in at an instruction boundary
`timescale 1ns/1ps
`default_nettype none

module tlih_core
  import tlih_pkg::*;
(
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  // register port
  input  wire tlih_bus_t          bus_in,
  output var  logic [7:0]         rd_data_out,
  // interrupt sources
  input  wire logic [NUM_SRC-1:0] src_event_in,
  input  wire logic [1:0]         ext_pin_n_in,
  // core sequencer
  input  wire logic               instr_done_in,
  input  wire logic               take_in,
  input  wire logic               return_from_service_in,
  output var  tlih_req_t          req_out,
  output var  tlih_svc_t          svc_out
);

  // ==========================================================
  // state
  logic               glb_en_r;
  logic [NUM_SRC-1:0] en_r;
  logic [NUM_SRC-1:0] pri_r;
  logic [NUM_SRC-1:0] pend_r;
  tlih_svc_t          svc_r;
  logic               hold_r;
  tlih_req_t          req_r;
  tlih_req_t          req_nxt;
  logic [7:0]         rd_data_r;
  logic [7:0]         rd_data_nxt;
  logic [1:0]         pin_s1_r;
  logic [1:0]         pin_s2_r;
  logic [1:0]         pin_s3_r;

  // ==========================================================
  // register decode
  logic               sel_en;
  logic               sel_pri;
  logic               sel_pnd;
  logic               sel_stat;
  logic [1:0]         lane;
  logic [23:0]        lane_mask24;
  logic [23:0]        wdata24;
  logic [NUM_SRC-1:0] wr_mask;
  logic [NUM_SRC-1:0] wr_val;

  always_comb begin
    sel_en   = 1'b0;
    sel_pri  = 1'b0;
    sel_pnd  = 1'b0;
    sel_stat = 1'b0;
    lane     = 2'd0;
    unique case (bus_in.addr)
      OFS_EN0: begin
        sel_en = 1'b1;
      end
      OFS_EN1: begin
        sel_en = 1'b1;
        lane   = 2'd1;
      end
      OFS_EN2: begin
        sel_en = 1'b1;
        lane   = 2'd2;
      end
      OFS_PRI0: begin
        sel_pri = 1'b1;
      end
      OFS_PRI1: begin
        sel_pri = 1'b1;
        lane    = 2'd1;
      end
      OFS_PRI2: begin
        sel_pri = 1'b1;
        lane    = 2'd2;
      end
      OFS_PND0: begin
        sel_pnd = 1'b1;
      end
      OFS_PND1: begin
        sel_pnd = 1'b1;
        lane    = 2'd1;
      end
      OFS_PND2: begin
        sel_pnd = 1'b1;
        lane    = 2'd2;
      end
      OFS_STAT: begin
        sel_stat = 1'b1;
      end
      default: begin
        lane = 2'd0;
      end
    endcase
  end

  assign lane_mask24 = 24'(24'h0000FF << {lane, 3'b000});
  assign wdata24     = 24'({16'h0000, bus_in.wdata} << {lane, 3'b000});
  assign wr_mask     = from_bytes(lane_mask24);
  assign wr_val      = from_bytes(wdata24) & wr_mask;

  // ==========================================================
  // enable and priority registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      glb_en_r <= GLB_EN_RST;
      en_r     <= EN_RST;
    end else if (bus_in.wr && sel_en) begin
      en_r <= (en_r & ~wr_mask) | wr_val;
      if (lane == 2'd0) begin
        glb_en_r <= bus_in.wdata[GLB_EN_BIT];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pri_r <= PRI_RST;
    end else if (bus_in.wr && sel_pri) begin
      pri_r <= (pri_r & ~wr_mask) | wr_val;
    end
  end

  // ==========================================================
  // external pins: two-flop sync, falling edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_s3_r <= 2'h3;
    end else begin
      pin_s1_r <= ext_pin_n_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ==========================================================
  // pending flags
  logic [NUM_SRC-1:0] evt;
  logic [NUM_SRC-1:0] hw_clr;
  logic [NUM_SRC-1:0] sw_set;
  logic [NUM_SRC-1:0] sw_clr;
  logic [NUM_SRC-1:0] set_v;

  always_comb begin
    evt           = src_event_in;
    evt[EXT0_SRC] = src_event_in[EXT0_SRC] | (pin_s3_r[0] & ~pin_s2_r[0]);
    evt[EXT1_SRC] = src_event_in[EXT1_SRC] | (pin_s3_r[1] & ~pin_s2_r[1]);
  end

  assign sw_set = (bus_in.wr && sel_pnd) ? wr_val : '0;
  assign sw_clr = (bus_in.wr && sel_pnd) ? (wr_mask & ~wr_val) : '0;
  assign hw_clr = (take_in && req_r.valid) ?
                  (HW_CLR_MASK & (NUM_SRC'(1) << req_r.src)) : '0;
  assign set_v  = evt | sw_set;

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_pend
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pend_r[i] <= PND_RST[i];
        end else if (set_v[i]) begin
          pend_r[i] <= 1'b1;
        end else if (sw_clr[i] || hw_clr[i]) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // arbitration, every cycle
  logic [NUM_SRC-1:0] cand;
  logic [NUM_SRC-1:0] hi_cand;
  logic [NUM_SRC-1:0] lo_cand;
  logic               allow_hi;
  logic               allow_lo;
  logic               pick_valid;

  assign cand     = pend_r & en_r & {NUM_SRC{glb_en_r}};
  assign hi_cand  = cand & pri_r;
  assign lo_cand  = cand & ~pri_r;
  assign allow_hi = (svc_r == SVC_IDLE) || (svc_r == SVC_LOW);
  assign allow_lo = (svc_r == SVC_IDLE);
  assign pick_valid = (allow_hi && (hi_cand != '0)) ||
                      (allow_lo && (lo_cand != '0));

  always_comb begin
    req_nxt.valid  = pick_valid && !hold_r && !take_in && !return_from_service_in;
    req_nxt.level  = LVL_LOW;
    req_nxt.src    = first_src(lo_cand);
    if (allow_hi && (hi_cand != '0)) begin
      req_nxt.level = LVL_HIGH;
      req_nxt.src   = first_src(hi_cand);
    end
    req_nxt.vector = VEC_BASE + {8'h00, req_nxt.src, 3'b000};
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_r <= '{valid: 1'b0, level: LVL_LOW, src: '0, vector: RESET_VEC};
    end else begin
      req_r <= req_nxt;
    end
  end

  // ==========================================================
  // after return, one instruction before a new request
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r <= 1'b0;
    end else if (return_from_service_in) begin
      hold_r <= 1'b1;
    end else if (instr_done_in) begin
      hold_r <= 1'b0;
    end
  end

  // ==========================================================
  // service nesting
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      svc_r <= SVC_IDLE;
    end else if (take_in && req_r.valid) begin
      unique case (svc_r)
        SVC_IDLE: begin
          svc_r <= (req_r.level == LVL_HIGH) ? SVC_HIGH : SVC_LOW;
        end
        SVC_LOW: begin
          svc_r <= SVC_NEST;
        end
        SVC_NEST, SVC_HIGH: begin
          svc_r <= svc_r;
        end
      endcase
    end else if (return_from_service_in) begin
      unique case (svc_r)
        SVC_IDLE, SVC_LOW, SVC_HIGH: begin
          svc_r <= SVC_IDLE;
        end
        SVC_NEST: begin
          svc_r <= SVC_LOW;
        end
      endcase
    end
  end

  // ==========================================================
  // read port
  logic [23:0] en24;
  logic [23:0] pri24;
  logic [23:0] pnd24;

  assign en24  = to_bytes(en_r);
  assign pri24 = to_bytes(pri_r);
  assign pnd24 = to_bytes(pend_r);

  always_comb begin
    rd_data_nxt = 8'h00;
    if (bus_in.rd) begin
      if (sel_en) begin
        rd_data_nxt = 8'(en24 >> {lane, 3'b000});
        if (lane == 2'd0) begin
          rd_data_nxt[GLB_EN_BIT] = glb_en_r;
        end
      end else if (sel_pri) begin
        rd_data_nxt = 8'(pri24 >> {lane, 3'b000});
      end else if (sel_pnd) begin
        rd_data_nxt = 8'(pnd24 >> {lane, 3'b000});
      end else if (sel_stat) begin
        rd_data_nxt = {4'h0, hold_r, req_r.valid, svc_r};
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign req_out     = req_r;
  assign svc_out     = svc_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  pend_set_a: assert property (
    (evt != '0) |=> ((pend_r & $past(evt)) == $past(evt)))
    else $error("source event did not set its flag");

  req_gate_a: assert property (
    (pick_valid && !hold_r && !take_in && !return_from_service_in) |=> req_r.valid)
    else $error("enabled pending source gave no request");

  ge_block_a: assert property (
    !glb_en_r |=> !req_r.valid)
    else $error("request raised with global enable clear");

  vector_a: assert property (
    req_r.valid |-> req_r.vector == VEC_BASE + {8'h00, req_r.src, 3'b000})
    else $error("vector does not match source");

  hw_clear_a: assert property (
    (take_in && req_r.valid && HW_CLR_MASK[req_r.src] && !set_v[req_r.src])
    |=> !pend_r[$past(req_r.src)])
    else $error("hardware-cleared flag still set after vectoring");

  return_from_service_hold_a: assert property (
    return_from_service_in ##1 (!instr_done_in)[*2] |=> !req_r.valid)
    else $error("request before the instruction after return");

  reenter_a: assert property (
    (hold_r && instr_done_in && !return_from_service_in && !take_in && pick_valid)
    |=> ##1 req_r.valid)
    else $error("no re-entry after one instruction");

  hi_no_preempt_a: assert property (
    (svc_r == SVC_HIGH || svc_r == SVC_NEST) |=> !req_r.valid)
    else $error("running high routine was preempted");

  lo_preempt_a: assert property (
    (svc_r == SVC_LOW && req_r.valid) |-> req_r.level == LVL_HIGH)
    else $error("low request during low service");

  nest_return_a: assert property (
    (svc_r == SVC_NEST && return_from_service_in) |=> svc_r == SVC_LOW)
    else $error("low routine lost after nested return");

  hi_first_a: assert property (
    (req_r.valid && req_r.level == LVL_LOW) |-> $past(hi_cand) == '0)
    else $error("low request chosen over high");

  low_taken_c: cover property (req_r.valid && take_in
                               && req_r.level == LVL_LOW);
  nest_c: cover property (svc_r == SVC_LOW ##1 svc_r == SVC_NEST);
  reenter_c: cover property (return_from_service_in ##[1:20] req_r.valid);

endmodule

`default_nettype wire

/* File: verif/tlih_core_model.sv */
// Purpose: core sequencer model facing the interrupt handler
// Assumes: one-cycle instructions; stall_in freezes the core
// Notes:   takes a standing request one cycle after it appears
`timescale 1ns/1ps
`default_nettype none
module tlih_core_model
  import tlih_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // bench control
  input  wire logic        stall_in,
  input  wire logic        return_from_service_req_in,
  // handler link
  input  wire tlih_req_t   req_in,
  output var  logic        instr_done_out,
  output var  logic        take_out,
  output var  logic        return_from_service_out,
  // observation
  output var  logic [7:0]  take_cnt_out,
  output var  logic [15:0] vec_out
);
  // ==========================================================
  // instruction flow and return
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      instr_done_out <= 1'b0;
      return_from_service_out       <= 1'b0;
      take_out       <= 1'b0;
    end else begin
      instr_done_out <= !stall_in && !return_from_service_req_in;
      return_from_service_out       <= return_from_service_req_in;
      take_out       <= !stall_in && !return_from_service_req_in && !take_out
                        && req_in.valid;
    end
  end

  // ==========================================================
  // long call bookkeeping
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      take_cnt_out <= 8'h00;
      vec_out      <= 16'h0000;
    end else if (take_out && req_in.valid) begin
      take_cnt_out <= take_cnt_out + 8'h01;
      vec_out      <= req_in.vector;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tlih_core_tb.sv */
// Purpose: self-checking bench of the interrupt handler
// Assumes: core model takes requests; bench drives registers
// Notes:   vectors are 0x0003 plus eight per source
`timescale 1ns/1ps
`default_nettype none
module tlih_core_tb;
  import tlih_pkg::*;
  logic               clock;
  logic               rst_n;
  tlih_bus_t          bus;
  logic [7:0]         rd_data;
  logic [NUM_SRC-1:0] src_ev;
  logic [1:0]         pin_n;
  logic               instr_done;
  logic               take;
  logic               return_from_service;
  tlih_req_t          req;
  tlih_svc_t          svc;
  logic               stall;
  logic               return_from_service_req;
  logic [7:0]         take_cnt;
  logic [15:0]        vec;
  logic [7:0]         seen;
  int                 fail_count;
  int                 comparisons;

  tlih_core u_dut (.clock_in(clock), .rst_n_in(rst_n), .bus_in(bus),
    .rd_data_out(rd_data), .src_event_in(src_ev), .ext_pin_n_in(pin_n),
    .instr_done_in(instr_done), .take_in(take), .return_from_service_in(return_from_service),
    .req_out(req), .svc_out(svc));

  tlih_core_model u_core (.clock_in(clock), .rst_n_in(rst_n),
    .stall_in(stall), .return_from_service_req_in(return_from_service_req), .req_in(req),
    .instr_done_out(instr_done), .take_out(take), .return_from_service_out(return_from_service),
    .take_cnt_out(take_cnt), .vec_out(vec));

  always #4 clock = ~clock;

  // ==========================================================
  // tasks
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clock);
    bus.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clock);
    bus.rd   <= 1'b0;
    @(negedge clock);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_data});
  endtask

  task automatic wait_take(input logic [15:0] e, input tlih_svc_t s);
    int i;
    for (i = 0; i < 60 && take_cnt == seen; i++) begin
      @(negedge clock);
    end
    if (take_cnt == seen) begin
      fail_count++;
      finish_test();
    end else begin
      seen = take_cnt;
      chk("vector", e, vec);
      chk("service", {14'h0000, s}, {14'h0000, svc});
    end
  endtask

  task automatic no_take(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
    chk("take count", {8'h00, seen}, {8'h00, take_cnt});
  endtask

  task automatic do_return_from_service();
    @(posedge clock);
    return_from_service_req <= 1'b1;
    @(posedge clock);
    return_from_service_req <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic ev(input int n);
    @(posedge clock);
    src_ev[n] <= 1'b1;
    @(posedge clock);
    src_ev    <= '0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    src_ev = '0;
    pin_n = 2'b11;
    stall = 1'b0;
    return_from_service_req = 1'b0;
    seen = 8'h00;
    fail_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFS_EN0, 8'h00);
    rd(OFS_PRI0, 8'h00);
    rd(OFS_PRI2, 8'h00);
    rd(OFS_STAT, 8'h00);
    rd(8'h0A, 8'h00);
    @(posedge clock);
    pin_n <= 2'b00;
    repeat (6) @(posedge clock);
    pin_n <= 2'b11;
    rd(OFS_PND0, 8'h05);
    ev(18);
    rd(OFS_PND2, 8'h08);
    wr(OFS_PND0, 8'h00);
    wr(OFS_PND2, 8'h00);
    wr(OFS_EN2, 8'hFF);
    rd(OFS_EN2, 8'h0F);
    wr(OFS_EN2, 8'h00);
    wr(OFS_EN0, 8'h20);
    ev(5);
    no_take(20);
    rd(OFS_PND0, 8'h20);
    wr(OFS_EN0, 8'hA0);
    wait_take(16'h002B, SVC_LOW);
    rd(OFS_PND0, 8'h20);
    rd(OFS_STAT, 8'h01);
    do_return_from_service();
    wait_take(16'h002B, SVC_LOW);
    wr(OFS_PND0, 8'h00);
    do_return_from_service();
    rd(OFS_STAT, 8'h00);
    wr(OFS_EN0, 8'h81);
    wr(OFS_PND0, 8'h01);
    wait_take(16'h0003, SVC_LOW);
    rd(OFS_PND0, 8'h00);
    do_return_from_service();
    @(posedge clock);
    stall <= 1'b1;
    wr(OFS_EN0, 8'h8A);
    wr(OFS_PND0, 8'h0A);
    @(posedge clock);
    stall <= 1'b0;
    wait_take(16'h000B, SVC_LOW);
    no_take(10);
    wr(OFS_PRI0, 8'h08);
    wait_take(16'h001B, SVC_NEST);
    rd(OFS_STAT, 8'h03);
    do_return_from_service();
    rd(OFS_STAT, 8'h01);
    do_return_from_service();
    rd(OFS_STAT, 8'h00);
    @(posedge clock);
    stall <= 1'b1;
    wr(OFS_PND0, 8'h0A);
    @(posedge clock);
    stall <= 1'b0;
    wait_take(16'h001B, SVC_HIGH);
    rd(OFS_STAT, 8'h02);
    do_return_from_service();
    wait_take(16'h000B, SVC_LOW);
    do_return_from_service();
    // mid-run reset: priorities and service state return to idle
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    seen = 8'h00;
    rd(OFS_PRI0, 8'h00);
    rd(OFS_STAT, 8'h00);
    chk("service", 16'h0000, {14'h0000, svc});
    finish_test();
  end
endmodule
`default_nettype wire
